/* File: common/gfm_pkg.sv */
// Package for the pin function mux: timing, baud limits, function codes.
// Assumes a single 20 MHz clock; the host packet protocol lives outside.
//
// Summary of operation
// R1 - All serial ports use fixed 8N1 framing: one start, eight data, one stop.
// R2 - After reset every serial port runs at 115200 baud.
// R3 - Primary port baud is settable from 2400 to 2000000 by configuration command.
// R4 - Primary port carries host packet protocol, requested or periodic packets.
// R5 - External aiding data arrives on primary port or on a pin serial receiver.
// R6 - Differential-primary variant has no auxiliary port.
// R7 - Serial function puts transmit on first pin, receive on second pin.
// R8 - Pin serial baud is configurable from 2400 to 250 K.
// R9 - Auxiliary baud is configurable from 2400 to 2 M, independently.
// R10 - Pin and auxiliary functions change at any time without restart.
// R11 - Pin is 0-5 V for digital and frequency, serial level when serial selected.
// R12 - Receive only on second pin or aux rx, transmit only on first pin or aux tx.
// R13 - Pulse-per-second output pulses 50 ms at the start of each second.
// R14 - Pulse-per-second starts about 100 ms after power-up and always fires.
// R15 - Satellite time correction may shorten one interval to realign pulses.
// R16 - A time-initialised flag tells whether time and pulses are valid.
// R17 - Pulse marked by falling edge on auxiliary port, rising edge on pins.
// R18 - Fix output low for none or 2D fix, high for 3D or better.
// R19 - Pin packet output sends only when requested through pin packet input.
// R20 - At reset every pin and the auxiliary port are inactive and tristated.

`default_nettype none

package gfm_pkg;

   // ==========================================================
   // Clock and timing
   localparam int unsigned CLK_HZ       = 20_000_000;
   localparam int unsigned PPS_PULSE_MS = 50;
   localparam int unsigned PPS_START_MS = 100;
   localparam int unsigned SECOND_MS    = 1000;
   localparam int unsigned PPS_PULSE_CYC = PPS_PULSE_MS * (CLK_HZ / 1000);
   localparam int unsigned PPS_START_CYC = PPS_START_MS * (CLK_HZ / 1000);
   localparam int unsigned SECOND_CYC    = SECOND_MS * (CLK_HZ / 1000);

   // ==========================================================
   // Serial framing and baud limits
   localparam int unsigned UART_OVS      = 8;
   localparam logic [3:0]  FRAME_BITS    = 4'd10;
   localparam logic [20:0] BAUD_DEFAULT  = 21'd115200;
   localparam logic [20:0] BAUD_MIN      = 21'd2400;
   localparam logic [20:0] BAUD_PRI_MAX  = 21'd2000000;
   localparam logic [20:0] BAUD_PIN_MAX  = 21'd250000;
   localparam logic [20:0] BAUD_AUX_MAX  = 21'd2000000;

   // Serial port indices
   localparam int unsigned PORT_PRI = 0;
   localparam int unsigned PORT_PIN = 1;
   localparam int unsigned PORT_AUX = 2;

   // Function targets
   localparam logic [1:0] TGT_PIN1   = 2'd0;
   localparam logic [1:0] TGT_PIN2   = 2'd1;
   localparam logic [1:0] TGT_AUX_TX = 2'd2;
   localparam logic [1:0] TGT_AUX_RX = 2'd3;

   // ==========================================================
   // Types
   typedef enum logic [3:0] {
      FN_INACTIVE = 4'h0,
      FN_PPS_OUT  = 4'h1,
      FN_FIX_OUT  = 4'h2,
      FN_FREQ_IN  = 4'h3,
      FN_DIG_IN   = 4'h4,
      FN_SER_RX   = 4'h5,
      FN_SER_TX   = 4'h6,
      FN_PKT_RX   = 4'h7,
      FN_PKT_TX   = 4'h8,
      FN_ENC_IN   = 4'h9,
      FN_PASS     = 4'ha
   } gfm_func_e;

   typedef enum logic [2:0] {
      FIX_NONE = 3'h0,
      FIX_2D   = 3'h1,
      FIX_3D   = 3'h2,
      FIX_SBAS = 3'h3,
      FIX_DIFF = 3'h4,
      FIX_RTK  = 3'h5
   } gfm_fix_e;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } gfm_byte_s;

endpackage

`default_nettype wire

/* File: logic/gfm_uart.sv */
// Fixed 8N1 serial transceiver with a phase-accumulator baud generator.
// Assumes rx_i is already synchronised to clk_i.

`default_nettype none

module gfm_uart #(
   parameter int unsigned CLK_HZ = gfm_pkg::CLK_HZ
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             nrst_i,
   // Configuration
   input  wire logic [20:0]      baud_i,
   // Transmit stream
   input  wire gfm_pkg::gfm_byte_s tx_i,
   output logic                  tx_ready_o,
   output logic                  tx_o,
   // Receive stream
   input  wire logic             rx_i,
   output gfm_pkg::gfm_byte_s    rx_o,
   output logic                  rx_ferr_o
);

   typedef enum logic [3:0] {
      RX_IDLE  = 4'b0001,
      RX_START = 4'b0010,
      RX_DATA  = 4'b0100,
      RX_STOP  = 4'b1000
   } gfm_rx_e;

   localparam logic [25:0] LIM = 26'(CLK_HZ);

   logic [25:0] acc_q;
   logic [25:0] acc_sum;
   logic        tick;
   logic [9:0]  tx_sh_q;
   logic [3:0]  tx_bits_q;
   logic [2:0]  tx_ph_q;
   gfm_rx_e     rx_st_q;
   logic [2:0]  rx_ph_q;
   logic [2:0]  rx_bits_q;
   logic [7:0]  rx_sh_q;

   // ==========================================================
   // Oversample tick, eight per bit; jitter is one clock at most
   assign acc_sum = acc_q + {2'b00, baud_i, 3'b000};
   assign tick    = acc_sum >= LIM;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         acc_q <= '0;
      end else begin
         acc_q <= tick ? acc_sum - LIM : acc_sum;
      end
   end

   // ==========================================================
   // Transmitter
   assign tx_ready_o = tx_bits_q == 4'd0;
   assign tx_o       = tx_sh_q[0];

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tx_sh_q   <= 10'h3ff;
         tx_bits_q <= 4'd0;
         tx_ph_q   <= 3'd0;
      end else if (tx_bits_q == 4'd0) begin
         if (tx_i.valid) begin
            tx_sh_q   <= {1'b1, tx_i.data, 1'b0}; // see R1
            tx_bits_q <= gfm_pkg::FRAME_BITS;
            tx_ph_q   <= 3'd0;
         end
      end else if (tick) begin
         tx_ph_q <= tx_ph_q + 3'd1;
         if (tx_ph_q == 3'd7) begin
            tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
            tx_bits_q <= tx_bits_q - 4'd1;
         end
      end
   end

   // ==========================================================
   // Receiver, samples mid-bit and checks the stop bit
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rx_st_q   <= RX_IDLE;
         rx_ph_q   <= 3'd0;
         rx_bits_q <= 3'd0;
         rx_sh_q   <= 8'h00;
         rx_o      <= '0;
         rx_ferr_o <= 1'b0;
      end else begin
         rx_o.valid <= 1'b0;
         rx_ferr_o  <= 1'b0;
         unique case (rx_st_q)
            RX_IDLE: begin
               rx_ph_q <= 3'd0;
               if (!rx_i) begin
                  rx_st_q <= RX_START;
               end
            end
            RX_START: if (tick) begin
               rx_ph_q <= rx_ph_q + 3'd1;
               if (rx_ph_q == 3'd3) begin
                  rx_ph_q   <= 3'd0;
                  rx_bits_q <= 3'd0;
                  rx_st_q   <= rx_i ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: if (tick) begin
               rx_ph_q <= rx_ph_q + 3'd1;
               if (rx_ph_q == 3'd7) begin
                  rx_sh_q   <= {rx_i, rx_sh_q[7:1]};
                  rx_bits_q <= rx_bits_q + 3'd1;
                  if (rx_bits_q == 3'd7) begin
                     rx_st_q <= RX_STOP;
                  end
               end
            end
            RX_STOP: if (tick) begin
               rx_ph_q <= rx_ph_q + 3'd1;
               if (rx_ph_q == 3'd7) begin
                  rx_st_q <= RX_IDLE;
                  if (rx_i) begin
                     rx_o.valid <= 1'b1; // see R1
                     rx_o.data  <= rx_sh_q;
                  end else begin
                     rx_ferr_o <= 1'b1;
                  end
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Checks
   a_tx_stop_high: assert property ( // see R1
      @(posedge clk_i) disable iff (!nrst_i)
      (tx_bits_q == 4'd1) |-> tx_o)
      else $error("stop bit not high");

   a_tx_start_low: assert property ( // see R1
      @(posedge clk_i) disable iff (!nrst_i)
      (tx_ready_o && tx_i.valid) |=> !tx_o && tx_bits_q == 4'd10)
      else $error("start bit not sent");

endmodule

`default_nettype wire

/* File: logic/gfm_top.sv */
// Pin function mux: pin and auxiliary function select, three serial ports,
// pulse-per-second and fix-status outputs.
// Assumes configuration strobes come from same-clock firmware logic and the
// packet protocol engine sits on the user-side byte streams.

`default_nettype none

module gfm_top #(
   parameter bit          HAS_AUX   = 1'b1,
   parameter int unsigned SEC_CYC   = gfm_pkg::SECOND_CYC,
   parameter int unsigned PULSE_CYC = gfm_pkg::PPS_PULSE_CYC,
   parameter int unsigned START_CYC = gfm_pkg::PPS_START_CYC
) (
   // Clock and reset
   input  wire logic               clk_i,
   input  wire logic               nrst_i,
   // Configuration commands
   input  wire logic               cfg_func_wr_i,
   input  wire logic [1:0]         cfg_target_i,
   input  wire gfm_pkg::gfm_func_e cfg_func_i,
   input  wire logic               cfg_baud_wr_i,
   input  wire logic [1:0]         cfg_port_i,
   input  wire logic [20:0]        cfg_baud_i,
   output logic                    cfg_err_o,
   // Time and fix status
   input  wire logic               time_fix_i,
   input  wire logic               time_valid_i,
   input  wire gfm_pkg::gfm_fix_e  fix_type_i,
   output logic                    time_init_o,
   // Byte streams: primary, pin, auxiliary
   input  wire gfm_pkg::gfm_byte_s tx_i [3],
   output logic                    tx_ready_o [3],
   output gfm_pkg::gfm_byte_s      rx_o [3],
   output logic                    rx_ferr_o [3],
   // Digital levels seen on pin1, pin2, aux receive
   output logic [2:0]              dig_in_o,
   output logic                    pin_pkt_en_o,
   // Primary serial pins
   input  wire logic               pri_rx_i,
   output logic                    pri_tx_o,
   // Multi-purpose pins
   input  wire logic               multi_pin_first_i,
   output logic                    multi_pin_first_o,
   output logic                    multi_pin_first_oe_o,
   output logic                    multi_pin_first_ser_o,
   input  wire logic               multi_pin_second_i,
   output logic                    multi_pin_second_o,
   output logic                    multi_pin_second_oe_o,
   output logic                    multi_pin_second_ser_o,
   // Auxiliary serial pins
   output logic                    aux_tx_o,
   output logic                    aux_tx_oe_o,
   input  wire logic               aux_rx_i
);

   logic [3:0]          pin_raw;
   logic [3:0]          meta_q;
   logic [3:0]          sync_q;
   gfm_pkg::gfm_func_e  fn_q [4];
   logic [20:0]         baud_q [3];
   logic                fn_legal;
   logic                baud_legal;
   logic [20:0]         baud_max;
   logic [24:0]         sec_cnt_q;
   logic [24:0]         start_cnt_q;
   logic                started_q;
   logic                pps_q;
   logic                fix_hi;
   logic                uart_tx [3];
   logic                uart_rx [3];
   logic                uart_rdy [3];
   gfm_pkg::gfm_byte_s  uart_txd [3];
   logic                pin_tx_fn;
   logic                pin_rx_fn;
   logic                aux_tx_fn;
   logic                aux_rx_fn;
   logic [24:0]         hi_len_q;

   // ==========================================================
   // Input synchronisers: pin1, pin2, aux rx, primary rx; reset to idle high
   assign pin_raw = {pri_rx_i, aux_rx_i, multi_pin_second_i, multi_pin_first_i};

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         meta_q <= 4'hf;
         sync_q <= 4'hf;
      end else begin
         meta_q <= pin_raw;
         sync_q <= meta_q;
      end
   end

   // ==========================================================
   // Function select with legality per target
   function automatic logic is_rx(gfm_pkg::gfm_func_e f);
      return f == gfm_pkg::FN_SER_RX || f == gfm_pkg::FN_PKT_RX;
   endfunction

   function automatic logic is_tx(gfm_pkg::gfm_func_e f);
      return f == gfm_pkg::FN_SER_TX || f == gfm_pkg::FN_PKT_TX;
   endfunction

   always_comb begin
      unique case (cfg_target_i)
         gfm_pkg::TGT_PIN1:   fn_legal = !is_rx(cfg_func_i); // see R12
         gfm_pkg::TGT_PIN2:   fn_legal = !is_tx(cfg_func_i); // see R12
         gfm_pkg::TGT_AUX_TX: fn_legal = HAS_AUX && (is_tx(cfg_func_i) ||
            cfg_func_i inside {gfm_pkg::FN_INACTIVE, gfm_pkg::FN_PPS_OUT,
                               gfm_pkg::FN_FIX_OUT, gfm_pkg::FN_PASS}); // see R6
         default:             fn_legal = HAS_AUX && (is_rx(cfg_func_i) ||
            cfg_func_i inside {gfm_pkg::FN_INACTIVE, gfm_pkg::FN_FREQ_IN,
                               gfm_pkg::FN_DIG_IN, gfm_pkg::FN_PASS});
      endcase
      unique case (cfg_port_i)
         2'd0:    baud_max = gfm_pkg::BAUD_PRI_MAX; // see R3
         2'd1:    baud_max = gfm_pkg::BAUD_PIN_MAX; // see R8
         default: baud_max = gfm_pkg::BAUD_AUX_MAX; // see R9
      endcase
      baud_legal = cfg_port_i != 2'd3 && cfg_baud_i >= gfm_pkg::BAUD_MIN &&
                   cfg_baud_i <= baud_max;
   end

   // Takes effect on the next clock, no restart needed
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fn_q <= '{default: gfm_pkg::FN_INACTIVE}; // see R20
      end else if (cfg_func_wr_i && fn_legal) begin
         fn_q[cfg_target_i] <= cfg_func_i; // see R10
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         baud_q <= '{default: gfm_pkg::BAUD_DEFAULT}; // see R2
      end else if (cfg_baud_wr_i && baud_legal) begin
         baud_q[cfg_port_i] <= cfg_baud_i;
      end
   end

   // Reports the last command, the function write when both strobe together; a rejected one leaves settings untouched
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cfg_err_o <= 1'b0;
      end else if (cfg_func_wr_i) begin
         cfg_err_o <= !fn_legal;
      end else if (cfg_baud_wr_i) begin
         cfg_err_o <= !baud_legal;
      end
   end

   // ==========================================================
   // Pulse per second; free-running whatever the time validity
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         start_cnt_q <= '0;
         started_q   <= 1'b0;
         sec_cnt_q   <= '0;
      end else if (!started_q) begin
         start_cnt_q <= start_cnt_q + 25'd1;
         started_q   <= start_cnt_q == 25'(START_CYC - 1); // see R14
      end else if (time_fix_i || sec_cnt_q == 25'(SEC_CYC - 1)) begin
         sec_cnt_q <= '0; // see R15
      end else begin
         sec_cnt_q <= sec_cnt_q + 25'd1;
      end
   end

   assign pps_q = started_q && sec_cnt_q < 25'(PULSE_CYC); // see R13

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         time_init_o <= 1'b0;
      end else begin
         time_init_o <= time_valid_i; // see R16
      end
   end

   assign fix_hi = fix_type_i inside {gfm_pkg::FIX_3D, gfm_pkg::FIX_SBAS,
                                      gfm_pkg::FIX_DIFF, gfm_pkg::FIX_RTK}; // see R18

   // ==========================================================
   // Serial ports
   assign pin_tx_fn = is_tx(fn_q[0]) || fn_q[0] == gfm_pkg::FN_PASS; // see R7
   assign pin_rx_fn = is_rx(fn_q[1]) || fn_q[1] == gfm_pkg::FN_PASS;
   assign aux_tx_fn = is_tx(fn_q[2]) || fn_q[2] == gfm_pkg::FN_PASS;
   assign aux_rx_fn = is_rx(fn_q[3]) || fn_q[3] == gfm_pkg::FN_PASS;
   // Packet output on a pin needs a packet input pin to request it
   assign pin_pkt_en_o = fn_q[0] != gfm_pkg::FN_PKT_TX ||
                         fn_q[1] == gfm_pkg::FN_PKT_RX; // see R19

   assign uart_rx[gfm_pkg::PORT_PRI] = sync_q[3]; // see R4
   assign uart_rx[gfm_pkg::PORT_PIN] = pin_rx_fn ? sync_q[1] : 1'b1; // see R5
   assign uart_rx[gfm_pkg::PORT_AUX] = aux_rx_fn ? sync_q[2] : 1'b1;

   genvar gi;
   for (gi = 0; gi < 3; gi++) begin : g_port
      logic open;
      assign open = gi == gfm_pkg::PORT_PRI ? 1'b1 :
                    gi == gfm_pkg::PORT_PIN ? pin_tx_fn && pin_pkt_en_o : aux_tx_fn;
      assign uart_txd[gi]   = '{valid: tx_i[gi].valid && open, data: tx_i[gi].data};
      assign tx_ready_o[gi] = uart_rdy[gi] && open;
      gfm_uart u_uart (
         .clk_i      (clk_i),
         .nrst_i     (nrst_i),
         .baud_i     (baud_q[gi]),
         .tx_i       (uart_txd[gi]),
         .tx_ready_o (uart_rdy[gi]),
         .tx_o       (uart_tx[gi]),
         .rx_i       (uart_rx[gi]),
         .rx_o       (rx_o[gi]),
         .rx_ferr_o  (rx_ferr_o[gi])
      );
   end

   assign pri_tx_o = uart_tx[gfm_pkg::PORT_PRI];

   // ==========================================================
   // Pin drivers, registered
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         multi_pin_first_o      <= 1'b0;
         multi_pin_first_oe_o   <= 1'b0;
         multi_pin_first_ser_o  <= 1'b0;
         multi_pin_second_o     <= 1'b0;
         multi_pin_second_oe_o  <= 1'b0;
         multi_pin_second_ser_o <= 1'b0;
         aux_tx_o               <= 1'b1;
         aux_tx_oe_o            <= 1'b0;
         dig_in_o               <= 3'b000;
      end else begin
         multi_pin_first_o <= fn_q[0] == gfm_pkg::FN_PPS_OUT ? pps_q : // see R17
                              fn_q[0] == gfm_pkg::FN_FIX_OUT ? fix_hi :
                              uart_tx[gfm_pkg::PORT_PIN];
         multi_pin_first_oe_o <= pin_tx_fn || fn_q[0] inside
            {gfm_pkg::FN_PPS_OUT, gfm_pkg::FN_FIX_OUT}; // see R20
         multi_pin_first_ser_o  <= pin_tx_fn; // see R11
         multi_pin_second_o     <= fn_q[1] == gfm_pkg::FN_PPS_OUT ? pps_q : fix_hi;
         multi_pin_second_oe_o  <= fn_q[1] inside {gfm_pkg::FN_PPS_OUT, gfm_pkg::FN_FIX_OUT};
         multi_pin_second_ser_o <= pin_rx_fn; // see R11
         // Falling edge marks the second on the auxiliary line
         aux_tx_o    <= fn_q[2] == gfm_pkg::FN_PPS_OUT ? !pps_q : // see R17
                        fn_q[2] == gfm_pkg::FN_FIX_OUT ? fix_hi :
                        uart_tx[gfm_pkg::PORT_AUX];
         aux_tx_oe_o <= fn_q[2] != gfm_pkg::FN_INACTIVE;
         dig_in_o[0] <= fn_q[0] inside {gfm_pkg::FN_DIG_IN, gfm_pkg::FN_FREQ_IN,
                                        gfm_pkg::FN_ENC_IN} && sync_q[0];
         dig_in_o[1] <= fn_q[1] inside {gfm_pkg::FN_DIG_IN, gfm_pkg::FN_FREQ_IN,
                                        gfm_pkg::FN_ENC_IN} && sync_q[1];
         dig_in_o[2] <= fn_q[3] inside {gfm_pkg::FN_DIG_IN, gfm_pkg::FN_FREQ_IN} &&
                        sync_q[2];
      end
   end

   // ==========================================================
   // Checks
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hi_len_q <= '0;
      end else begin
         hi_len_q <= pps_q ? hi_len_q + 25'd1 : '0;
      end
   end

   sequence s_pps_end;
      $fell(pps_q) && !$past(time_fix_i);
   endsequence

   sequence s_pps_fix;
      started_q && time_fix_i;
   endsequence

   a_pps_width: assert property (@(posedge clk_i) disable iff (!nrst_i) // see R13
      s_pps_end |-> hi_len_q == 25'(PULSE_CYC))
      else $error("pps pulse width wrong");

   a_pps_start: assert property (@(posedge clk_i) disable iff (!nrst_i) // see R14
      $rose(started_q) |-> start_cnt_q == 25'(START_CYC) && pps_q)
      else $error("pps start time wrong");

   a_pps_realign: assert property (@(posedge clk_i) disable iff (!nrst_i) // see R15
      s_pps_fix |=> sec_cnt_q == '0 ##1 pps_q)
      else $error("pps not realigned");

   a_fix_level: assert property (@(posedge clk_i) disable iff (!nrst_i) // see R18
      fn_q[0] == gfm_pkg::FN_FIX_OUT |=>
      multi_pin_first_o == ($past(fix_type_i) >= gfm_pkg::FIX_3D) && multi_pin_first_oe_o)
      else $error("fix level wrong");

   a_aux_pps_inv: assert property (@(posedge clk_i) disable iff (!nrst_i) // see R17
      fn_q[2] == gfm_pkg::FN_PPS_OUT |=> aux_tx_o == !$past(pps_q))
      else $error("aux pps polarity wrong");

   a_idle_tristate: assert property (@(posedge clk_i) disable iff (!nrst_i) // see R20
      fn_q[0] == gfm_pkg::FN_INACTIVE && fn_q[2] == gfm_pkg::FN_INACTIVE |=>
      !multi_pin_first_oe_o && !aux_tx_oe_o)
      else $error("inactive pin driven");

   a_illegal_reject: assert property (@(posedge clk_i) disable iff (!nrst_i) // see R12
      cfg_func_wr_i && cfg_target_i == gfm_pkg::TGT_PIN2 && is_tx(cfg_func_i) |=>
      fn_q[1] == $past(fn_q[1]) && cfg_err_o)
      else $error("illegal function taken");

   a_baud_range: assert property (@(posedge clk_i) disable iff (!nrst_i) // see R8
      cfg_baud_wr_i && cfg_port_i == 2'd1 && cfg_baud_i > gfm_pkg::BAUD_PIN_MAX |=>
      $stable(baud_q[1]) && cfg_err_o)
      else $error("pin baud out of range taken");

   a_pkt_gate: assert property (@(posedge clk_i) disable iff (!nrst_i) // see R19
      fn_q[0] == gfm_pkg::FN_PKT_TX && fn_q[1] != gfm_pkg::FN_PKT_RX |->
      !tx_ready_o[gfm_pkg::PORT_PIN])
      else $error("unrequested pin packet output");

   a_serial_mode: assert property (@(posedge clk_i) disable iff (!nrst_i) // see R11
      is_tx(fn_q[0]) ##1 is_tx(fn_q[0]) |-> multi_pin_first_ser_o)
      else $error("serial level not selected");

endmodule

`default_nettype wire

/* File: verification/gfm_far_end.sv */
// Far-side model: each transmit line wired back to its receive line.
// Assumes undriven receive lines rest on the on-board pull-up.
`default_nettype none
module gfm_far_end (
   input  wire logic pri_tx_i,
   input  wire logic pin1_i,
   input  wire logic pin1_oe_i,
   input  wire logic aux_i,
   input  wire logic aux_oe_i,
   output logic      pri_rx_o,
   output logic      pin2_o,
   output logic      aux_rx_o
);
   timeunit 1ns;
   timeprecision 1ns;
   assign pri_rx_o = pri_tx_i;
   assign pin2_o   = pin1_oe_i ? pin1_i : 1'b1;
   assign aux_rx_o = aux_oe_i ? aux_i : 1'b1;
endmodule
`default_nettype wire

/* File: verification/gfm_top_tb_top.sv */
// Bench for the pin function mux, with loopback far side.
// Assumes the shortened second of 200 cycles.
`default_nettype none
module gfm_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic               clk_i = 1'b0;
   logic               nrst_i = 1'b0;
   logic               fwr = 1'b0;
   logic               bwr = 1'b0;
   logic               tfix = 1'b0;
   logic               tval = 1'b0;
   logic [1:0]         tgt = 2'h0;
   logic [1:0]         port = 2'h0;
   logic [20:0]        baud = 21'h0;
   gfm_pkg::gfm_func_e fn = gfm_pkg::FN_INACTIVE;
   gfm_pkg::gfm_fix_e  fix = gfm_pkg::FIX_NONE;
   gfm_pkg::gfm_byte_s tx [3] = '{default: 9'h0};
   gfm_pkg::gfm_byte_s rx [3];
   logic               rdy [3];
   logic               err, tinit, pri_rx, pri_tx, p1_o, p1_oe, p1_ser;
   logic               p2_i, p2_o, p2_oe, p2_ser, ax_o, ax_oe, ax_i;
   logic               pen;
   logic [2:0]         dig;
   int                 fails = 0;
   int                 compares = 0;
   int                 n1, n2;

   always #25 clk_i = ~clk_i;

   gfm_top #(.SEC_CYC(200), .PULSE_CYC(10), .START_CYC(20)) u_gfm_top (
      .clk_i(clk_i), .nrst_i(nrst_i), .cfg_func_wr_i(fwr), .cfg_target_i(tgt),
      .cfg_func_i(fn), .cfg_baud_wr_i(bwr), .cfg_port_i(port), .cfg_baud_i(baud),
      .cfg_err_o(err), .time_fix_i(tfix), .time_valid_i(tval), .fix_type_i(fix),
      .time_init_o(tinit), .tx_i(tx), .tx_ready_o(rdy), .rx_o(rx), .rx_ferr_o(),
      .dig_in_o(dig), .pin_pkt_en_o(pen), .pri_rx_i(pri_rx), .pri_tx_o(pri_tx),
      .multi_pin_first_i(1'b1), .multi_pin_first_o(p1_o),
      .multi_pin_first_oe_o(p1_oe), .multi_pin_first_ser_o(p1_ser),
      .multi_pin_second_i(p2_i), .multi_pin_second_o(p2_o),
      .multi_pin_second_oe_o(p2_oe), .multi_pin_second_ser_o(p2_ser),
      .aux_tx_o(ax_o), .aux_tx_oe_o(ax_oe), .aux_rx_i(ax_i));

   gfm_far_end u_gfm_far_end (.pri_tx_i(pri_tx), .pin1_i(p1_o), .pin1_oe_i(p1_oe),
      .aux_i(ax_o), .aux_oe_i(ax_oe), .pri_rx_o(pri_rx), .pin2_o(p2_i), .aux_rx_o(ax_i));

   // ===============================
   // Tasks
   task automatic conclude();
      if (fails == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e) begin
         fails++;
         $display("unexpected %s exp %h got %h", n, e, s);
      end
   endtask

   task automatic fset(input logic [1:0] t, input gfm_pkg::gfm_func_e f, input logic e);
      fwr = 1'b1;
      tgt = t;
      fn = f;
      @(negedge clk_i);
      fwr = 1'b0;
      @(negedge clk_i);
      chk("cfg_err", 32'(e), 32'(err));
   endtask

   task automatic bset(input logic [1:0] p, input logic [20:0] b, input logic e);
      bwr = 1'b1;
      port = p;
      baud = b;
      @(negedge clk_i);
      bwr = 1'b0;
      @(negedge clk_i);
      chk("cfg_err", 32'(e), 32'(err));
   endtask

   // Byte returns through the loopback far side
   task automatic xfer(input int p, input logic [7:0] d);
      chk("tx_ready", 32'h1, 32'(rdy[p]));
      tx[p] = {1'b1, d};
      @(negedge clk_i);
      tx[p] = 9'h0;
      for (int i = 0; i < 2500 && rx[p].valid !== 1'b1; i++) @(negedge clk_i);
      chk("rx_byte", {23'h0, 1'b1, d}, 32'(rx[p]));
   endtask

   // ===============================
   // Tests
   initial begin
      repeat (5) @(negedge clk_i);
      nrst_i = 1'b1;
      chk("oe", 32'h0, {p1_oe, p2_oe, ax_oe});
      fset(2'h0, gfm_pkg::FN_SER_RX, 1'b1);
      fset(2'h1, gfm_pkg::FN_SER_TX, 1'b1);
      fset(2'h3, gfm_pkg::FN_ENC_IN, 1'b1);
      bset(2'h1, 21'd250001, 1'b1);
      bset(2'h0, 21'd2399, 1'b1);
      bset(2'h2, 21'd2000001, 1'b1);
      bset(2'h0, 21'd2000000, 1'b0);
      bset(2'h1, 21'd250000, 1'b0);
      fset(2'h0, gfm_pkg::FN_SER_TX, 1'b0);
      fset(2'h1, gfm_pkg::FN_SER_RX, 1'b0);
      fset(2'h2, gfm_pkg::FN_SER_TX, 1'b0);
      fset(2'h3, gfm_pkg::FN_SER_RX, 1'b0);
      chk("ser_mode", 32'h3, {p1_ser, p2_ser});
      xfer(0, 8'ha5);
      xfer(1, 8'h3c);
      xfer(2, 8'hc3);
      fset(2'h0, gfm_pkg::FN_PKT_TX, 1'b0);
      chk("pkt_en", 32'h0, 32'({pen, rdy[1]}));
      fset(2'h1, gfm_pkg::FN_PKT_RX, 1'b0);
      chk("pkt_en", 32'h3, 32'({pen, rdy[1]}));
      fset(2'h0, gfm_pkg::FN_PPS_OUT, 1'b0);
      fset(2'h2, gfm_pkg::FN_PPS_OUT, 1'b0);
      n1 = 0;
      n2 = 0;
      repeat (200) begin
         @(negedge clk_i);
         n1 += 32'(p1_o === 1'b1);
         n2 += 32'(ax_o === 1'b0);
      end
      chk("pin_pps", 32'd10, n1);
      chk("aux_pps", 32'd10, n2);
      // Correction one clock after a pulse ends, so a restart is visible
      wait (p1_o === 1'b1);
      wait (p1_o === 1'b0);
      @(negedge clk_i);
      tfix = 1'b1;
      @(negedge clk_i);
      tfix = 1'b0;
      repeat (3) @(negedge clk_i);
      chk("pps_realign", 32'h1, 32'(p1_o));
      fset(2'h0, gfm_pkg::FN_FIX_OUT, 1'b0);
      fset(2'h1, gfm_pkg::FN_FIX_OUT, 1'b0);
      for (int f = 0; f < 6; f++) begin
         fix = gfm_pkg::gfm_fix_e'(f);
         repeat (3) @(negedge clk_i);
         chk("fix_out", 32'({2{f >= 2}}), 32'({p1_o, p2_o}));
      end
      // Pin2 as digital input reads pin1's fix level through the far side
      fset(2'h1, gfm_pkg::FN_DIG_IN, 1'b0);
      fix = gfm_pkg::FIX_NONE;
      repeat (5) @(negedge clk_i);
      chk("dig_in", 32'h0, 32'(dig));
      fix = gfm_pkg::FIX_3D;
      repeat (5) @(negedge clk_i);
      chk("dig_in", 32'h2, 32'(dig));
      tval = 1'b1;
      repeat (2) @(negedge clk_i);
      chk("time_init", 32'h1, 32'(tinit));
      conclude();
   end

   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      conclude();
   end
endmodule
`default_nettype wire
